/* File: logic/frame_tick_gen.sv */
// Purpose: Divides pclk down to a one-cycle end-of-frame enable pulse.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: The count restarts whenever counting is stopped, so a frame always lasts in full.
`timescale 1ns/10ps
`default_nettype none
module frame_tick_gen
   import hc_regs_pkg::*;
#(
   parameter int CYCLES = FRAME_CYCLES
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Control and pulse.
   input wire logic run,
   output logic frame_tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } tick_state_t;

   tick_state_t st_r;
   tick_state_t st_nxt;

   // Count pclk cycles of the frame while running; the tick is registered to keep it glitch free.
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!run) begin
         st_nxt.cnt = 16'h0000;
      end else if (st_r.cnt == 16'(CYCLES - 1)) begin
         st_nxt.cnt = 16'h0000;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 16'h0001;
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign frame_tick = st_r.tick;
endmodule
`default_nettype wire

/* File: logic/hc_irq_frame_regs.sv */
// Purpose: Interrupt enables, status, frame index and list pointer registers over APB.
// Assumes: Zero-wait APB slave; events arrive as one-cycle pulses on pclk.
// Notes: Read data is captured in the setup cycle, so it comes straight from flip-flops.
// Notes on behaviour
// - Async advance interrupts at threshold boundary.
// - System error interrupts immediately when enabled.
// - Rollover interrupts immediately, gated by enable.
// - Port change interrupts immediately when enabled.
// - Transfer error interrupts at threshold boundary.
// - Transfer complete interrupts at threshold boundary.
// - Fourteen-bit frame index increments each frame.
// - Periodic base keeps bits 31-12, rest zero.
// - Async pointer keeps bits 31-5, rest zero.
// - Enable bits 31-6 read zero, ignore writes.
// - Frame index wrap sets rollover flag.
// - Retired descriptor with completion flag sets complete.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module hc_irq_frame_regs
   import hc_regs_pkg::*;
#(
   parameter int FRAME_LEN = FRAME_CYCLES
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Schedule engines.
   input wire hc_events_t events,
   input wire logic async_ptr_load,
   input wire logic [31:0] async_ptr_value,
   output logic [31:0] periodic_list_base,
   output logic [31:0] async_list_pointer,
   output logic [13:0] frame_index,
   output logic configured_bit,
   // Interrupt.
   output logic irq
);
   typedef struct packed {
      logic [5:0] enable;
      logic [5:0] status;
      logic [5:0] qualified;
      logic [13:0] fidx;
      logic [7:0] thr_cnt;
      logic [7:0] threshold;
      logic run;
      logic [19:0] pbase;
      logic [26:0] aptr;
      logic cfg;
      logic [31:0] rdata;
      logic slverr;
      logic irq;
   } regs_state_t;

   regs_state_t st_r;
   regs_state_t st_nxt;
   logic frame_tick;
   logic setup;
   logic wr;
   logic boundary;
   logic fidx_wr;
   logic [5:0] set_vec;
   logic [5:0] clr_vec;
   logic [7:0] thr_eff;

   // Frame divider; it only runs while software has the controller running.
   frame_tick_gen #(
      .CYCLES(FRAME_LEN)
   ) u_frame_tick (
      .pclk(pclk),
      .presetn(presetn),
      .run(st_r.run),
      .frame_tick(frame_tick)
   );

   // Bus phase decode; a write lands only on the access edge.
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign fidx_wr = wr && (paddr == OFS_FRAME_INDEX);
   assign clr_vec = (wr && paddr == OFS_HOST_STATUS) ? pwdata[5:0] : 6'h00;
   // A threshold of zero would never expire, so it behaves as one frame.
   assign thr_eff = (st_r.threshold == 8'h00) ? 8'h01 : st_r.threshold;
   assign boundary = frame_tick && (st_r.thr_cnt + 8'h01 >= thr_eff);

   // Hardware set events for the sticky flags.
   always_comb begin
      set_vec = 6'h00;
      set_vec[SRC_ASYNC_ADV] = events.async_advance;
      set_vec[SRC_SYS_ERROR] = events.system_error;
      set_vec[SRC_PORT_CHANGE] = events.port_change;
      set_vec[SRC_XFER_ERROR] = events.transfer_error;
      set_vec[SRC_COMPLETE] = events.td_retire && events.interrupt_on_complete;
      if (frame_tick && !fidx_wr && st_r.fidx == FRAME_INDEX_MAX) begin
         set_vec[SRC_ROLLOVER] = 1'b1;
      end
   end

   // Next state of the whole register bank.
   always_comb begin
      st_nxt = st_r;
      // Frame index counting and the threshold frame counter.
      if (frame_tick) begin
         st_nxt.fidx = st_r.fidx + 14'h0001;
         st_nxt.thr_cnt = boundary ? 8'h00 : st_r.thr_cnt + 8'h01;
      end
      // Software writes.
      if (wr) begin
         unique case (paddr)
            OFS_HC_CONTROL: begin
               st_nxt.run = pwdata[CTRL_RUN_BIT];
               st_nxt.threshold = pwdata[CTRL_THR_LSB +: THR_W];
            end
            OFS_HOST_IRQ_ENABLE: begin
               st_nxt.enable = pwdata[5:0];
            end
            OFS_FRAME_INDEX: begin
               st_nxt.fidx = pwdata[FRAME_INDEX_W-1:0];
            end
            OFS_PERIODIC_BASE: begin
               st_nxt.pbase = pwdata[31:PBASE_LSB];
            end
            OFS_ASYNC_POINTER: begin
               st_nxt.aptr = pwdata[31:APTR_LSB];
            end
            OFS_CONFIGURED_FLAG: begin
               st_nxt.cfg = pwdata[0];
            end
            default: begin
            end
         endcase
      end
      // The engine advancing the asynchronous list overrides a software write.
      if (async_ptr_load) begin
         st_nxt.aptr = async_ptr_value[31:APTR_LSB];
      end
      // Set wins over a write-one-to-clear in the same cycle.
      st_nxt.status = (st_r.status & ~clr_vec) | set_vec;
      // Deferred sources qualify at a boundary and stay so until acknowledged.
      st_nxt.qualified = (st_r.qualified
                          | ({6{boundary}} & st_nxt.status & DEFERRED_MASK))
                         & st_nxt.status;
      // Immediate sources need no qualification.
      st_nxt.irq = |(st_nxt.status & st_nxt.enable
                     & (IMMEDIATE_MASK | st_nxt.qualified));
      // Read data and error are captured in the setup cycle.
      if (setup) begin
         st_nxt.slverr = 1'b0;
         st_nxt.rdata = 32'h0000_0000;
         unique case (paddr)
            OFS_HC_CONTROL: begin
               st_nxt.rdata[CTRL_RUN_BIT] = st_r.run;
               st_nxt.rdata[CTRL_THR_LSB +: THR_W] = st_r.threshold;
            end
            OFS_HOST_STATUS: begin
               st_nxt.rdata[5:0] = st_r.status;
            end
            OFS_HOST_IRQ_ENABLE: begin
               st_nxt.rdata[5:0] = st_r.enable;
            end
            OFS_FRAME_INDEX: begin
               st_nxt.rdata[FRAME_INDEX_W-1:0] = st_r.fidx;
            end
            OFS_PERIODIC_BASE: begin
               st_nxt.rdata[31:PBASE_LSB] = st_r.pbase;
            end
            OFS_ASYNC_POINTER: begin
               st_nxt.rdata[31:APTR_LSB] = st_r.aptr;
            end
            OFS_CONFIGURED_FLAG: begin
               st_nxt.rdata[0] = st_r.cfg;
            end
            default: begin
               st_nxt.slverr = 1'b1;
            end
         endcase
      end
   end

   // State register; list pointers have no documented reset and start at zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.enable <= IRQ_ENABLE_RESET;
         st_r.fidx <= FRAME_INDEX_RESET;
         st_r.threshold <= THRESHOLD_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs.
   assign pready = 1'b1;
   assign prdata = st_r.rdata;
   assign pslverr = st_r.slverr && psel && penable;
   assign periodic_list_base = {st_r.pbase, 12'h000};
   assign async_list_pointer = {st_r.aptr, 5'h00};
   assign frame_index = st_r.fidx;
   assign configured_bit = st_r.cfg;
   assign irq = st_r.irq;

   // Checks.
   property p_sys_err_now;
      @(posedge pclk) disable iff (!presetn)
      (events.system_error && st_r.enable[SRC_SYS_ERROR]
       && !(wr && paddr == OFS_HOST_IRQ_ENABLE)) |=> irq;
   endproperty
   a_sys_err_now: assert property (p_sys_err_now) else $error("system error not raised");

   property p_port_now;
      @(posedge pclk) disable iff (!presetn)
      (events.port_change && st_r.enable[SRC_PORT_CHANGE]
       && !(wr && paddr == OFS_HOST_IRQ_ENABLE)) |=> irq;
   endproperty
   a_port_now: assert property (p_port_now) else $error("port change irq late");

   property p_rollover_now;
      @(posedge pclk) disable iff (!presetn)
      (frame_tick && !fidx_wr && st_r.fidx == FRAME_INDEX_MAX && st_r.enable[SRC_ROLLOVER]
       && !(wr && paddr == OFS_HOST_IRQ_ENABLE)) |=> irq;
   endproperty
   a_rollover_now: assert property (p_rollover_now) else $error("rollover irq missing");

   property p_async_waits;
      @(posedge pclk) disable iff (!presetn)
      $rose(st_r.qualified[SRC_ASYNC_ADV]) |-> $past(boundary);
   endproperty
   a_async_waits: assert property (p_async_waits) else $error("async advance early");

   property p_deferred_quiet;
      @(posedge pclk) disable iff (!presetn)
      ((st_r.status & st_r.enable & IMMEDIATE_MASK) == 6'h00 && st_r.qualified == 6'h00)
      |-> !irq;
   endproperty
   a_deferred_quiet: assert property (p_deferred_quiet) else $error("irq before threshold");

   property p_complete_at_boundary;
      @(posedge pclk) disable iff (!presetn)
      (boundary && st_r.status[SRC_COMPLETE] && st_r.enable[SRC_COMPLETE]
       && !clr_vec[SRC_COMPLETE] && !wr) |=> irq;
   endproperty
   a_complete_at_boundary: assert property (p_complete_at_boundary)
      else $error("no irq at boundary");

   property p_fidx_inc;
      @(posedge pclk) disable iff (!presetn)
      (frame_tick && !fidx_wr) |=> (st_r.fidx == $past(st_r.fidx) + 14'h0001);
   endproperty
   a_fidx_inc: assert property (p_fidx_inc) else $error("frame index not incremented");

   property p_wrap_flag;
      @(posedge pclk) disable iff (!presetn)
      (frame_tick && !fidx_wr && st_r.fidx == FRAME_INDEX_MAX)
      |=> (st_r.status[SRC_ROLLOVER] && st_r.fidx == 14'h0000);
   endproperty
   a_wrap_flag: assert property (p_wrap_flag) else $error("rollover flag not set");

   property p_complete_set;
      @(posedge pclk) disable iff (!presetn)
      (events.td_retire && events.interrupt_on_complete) |=> st_r.status[SRC_COMPLETE];
   endproperty
   a_complete_set: assert property (p_complete_set) else $error("complete flag not set");

   property p_pbase_low;
      @(posedge pclk) disable iff (!presetn)
      $past(setup && paddr == OFS_PERIODIC_BASE) |-> (prdata[11:0] == 12'h000);
   endproperty
   a_pbase_low: assert property (p_pbase_low) else $error("periodic base low bits set");

   property p_aptr_low;
      @(posedge pclk) disable iff (!presetn)
      $past(setup && paddr == OFS_ASYNC_POINTER) |-> (prdata[4:0] == 5'h00);
   endproperty
   a_aptr_low: assert property (p_aptr_low) else $error("async pointer low bits set");

   property p_enable_reserved;
      @(posedge pclk) disable iff (!presetn)
      $past(setup && paddr == OFS_HOST_IRQ_ENABLE) |-> (prdata[31:6] == 26'h0);
   endproperty
   a_enable_reserved: assert property (p_enable_reserved) else $error("reserved bits set");

   property p_pending_holds;
      @(posedge pclk) disable iff (!presetn)
      (st_r.status[SRC_XFER_ERROR] && !clr_vec[SRC_XFER_ERROR]) |=> st_r.status[SRC_XFER_ERROR];
   endproperty
   a_pending_holds: assert property (p_pending_holds) else $error("flag lost");

   property p_irq_or;
      @(posedge pclk) disable iff (!presetn)
      irq == |(st_r.status & st_r.enable & (IMMEDIATE_MASK | st_r.qualified));
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("irq not the OR of sources");

   // The OR check above cannot see timing, so these watch causes and their effects.
   property p_xfer_err_waits;
      @(posedge pclk) disable iff (!presetn)
      $rose(st_r.qualified[SRC_XFER_ERROR]) |-> $past(boundary);
   endproperty
   a_xfer_err_waits: assert property (p_xfer_err_waits) else $error("error too early");

   property p_complete_waits;
      @(posedge pclk) disable iff (!presetn)
      $rose(st_r.qualified[SRC_COMPLETE]) |-> $past(boundary);
   endproperty
   a_complete_waits: assert property (p_complete_waits) else $error("complete too early");

   property p_clear_drops;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == OFS_HOST_STATUS && pwdata[SRC_SYS_ERROR] && !set_vec[SRC_SYS_ERROR])
      |=> !st_r.status[SRC_SYS_ERROR];
   endproperty
   a_clear_drops: assert property (p_clear_drops) else $error("flag not cleared");

   property p_fidx_hold;
      @(posedge pclk) disable iff (!presetn)
      (!frame_tick && !fidx_wr) |=> $stable(st_r.fidx);
   endproperty
   a_fidx_hold: assert property (p_fidx_hold) else $error("frame index drifted");

   property p_enable_write;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == OFS_HOST_IRQ_ENABLE) |=> (st_r.enable == $past(pwdata[5:0]));
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost");

   property p_pbase_write;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == OFS_PERIODIC_BASE)
      |=> (periodic_list_base[31:PBASE_LSB] == $past(pwdata[31:PBASE_LSB]));
   endproperty
   a_pbase_write: assert property (p_pbase_write) else $error("periodic base write lost");

   property p_aptr_engine;
      @(posedge pclk) disable iff (!presetn)
      async_ptr_load
      |=> (async_list_pointer[31:APTR_LSB] == $past(async_ptr_value[31:APTR_LSB]));
   endproperty
   a_aptr_engine: assert property (p_aptr_engine) else $error("pointer load lost");
endmodule
`default_nettype wire

/* File: logic/hc_regs_pkg.sv */
// Purpose: Shared constants and types for the host controller interrupt and frame register bank.
// Assumes: 32-bit APB data, byte addresses, pclk at 50 MHz.
// Notes: Bit order of the six interrupt sources is shared by status, enable and qualify vectors.
package hc_regs_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_HC_CONTROL = 8'h20;
   localparam logic [7:0] OFS_HOST_STATUS = 8'h24;
   localparam logic [7:0] OFS_HOST_IRQ_ENABLE = 8'h28;
   localparam logic [7:0] OFS_FRAME_INDEX = 8'h2C;
   localparam logic [7:0] OFS_PERIODIC_BASE = 8'h34;
   localparam logic [7:0] OFS_ASYNC_POINTER = 8'h38;
   localparam logic [7:0] OFS_CONFIGURED_FLAG = 8'h60;
   // Source bit positions.
   localparam int SRC_COMPLETE = 0;
   localparam int SRC_XFER_ERROR = 1;
   localparam int SRC_PORT_CHANGE = 2;
   localparam int SRC_ROLLOVER = 3;
   localparam int SRC_SYS_ERROR = 4;
   localparam int SRC_ASYNC_ADV = 5;
   localparam int NUM_SRC = 6;
   // Sources that interrupt at once; the rest wait for the threshold boundary.
   localparam logic [5:0] IMMEDIATE_MASK = 6'h1C;
   localparam logic [5:0] DEFERRED_MASK = 6'h23;
   // Field layout.
   localparam int FRAME_INDEX_W = 14;
   localparam int PBASE_LSB = 12;
   localparam int APTR_LSB = 5;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_THR_LSB = 8;
   localparam int THR_W = 8;
   // Reset values.
   localparam logic [5:0] IRQ_ENABLE_RESET = 6'h00;
   localparam logic [13:0] FRAME_INDEX_RESET = 14'h0000;
   localparam logic [7:0] THRESHOLD_RESET = 8'h08;
   localparam logic [13:0] FRAME_INDEX_MAX = 14'h3FFF;
   // Timing.
   localparam int CLK_PERIOD_NS = 20;
   localparam int FRAME_TIME_NS = 125000;
   localparam int FRAME_CYCLES = FRAME_TIME_NS / CLK_PERIOD_NS;

   // Events from the schedule engines, one-cycle pulses on pclk.
   typedef struct packed {
      logic async_advance;
      logic system_error;
      logic port_change;
      logic transfer_error;
      logic td_retire;
      logic interrupt_on_complete;
   } hc_events_t;
endpackage

/* File: verification/engine_model.sv */
// Purpose: Stand-in for the schedule engines that pulse events.
// Assumes: Bench requests last one cycle.
// Notes: An idle pointer bus shows the inverse of its last value, so stale data is never read.
`timescale 1ns/10ps
`default_nettype none
module engine_model
   import hc_regs_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Requests from the bench.
   input wire logic [5:0] fire,
   input wire logic retire_only,
   input wire logic load,
   input wire logic [31:0] value,
   // Engine side.
   output hc_events_t events,
   output logic async_ptr_load,
   output logic [31:0] async_ptr_value
);
   // Each request becomes a one-cycle pulse after the next edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         events <= '0;
         async_ptr_load <= 1'b0;
         async_ptr_value <= 32'h0;
      end else begin
         events.async_advance <= fire[SRC_ASYNC_ADV];
         events.system_error <= fire[SRC_SYS_ERROR];
         events.port_change <= fire[SRC_PORT_CHANGE];
         events.transfer_error <= fire[SRC_XFER_ERROR];
         events.td_retire <= fire[SRC_COMPLETE] | retire_only;
         events.interrupt_on_complete <= fire[SRC_COMPLETE];
         async_ptr_load <= load;
         async_ptr_value <= load ? value : ~async_ptr_value;
      end
   end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the interrupt and frame register bank.
// Assumes: Zero-wait APB slave, short frames through FRAME_LEN.
// Notes: Threshold is set to one frame, two in t_thr, so deferred sources resolve quickly.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import hc_regs_pkg::*;
   localparam int FL = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   hc_events_t events;
   logic async_ptr_load;
   logic [31:0] async_ptr_value;
   logic [31:0] periodic_list_base;
   logic [31:0] async_list_pointer;
   logic [13:0] frame_index;
   logic configured_bit;
   logic irq;
   logic [5:0] fire = 6'h00;
   logic retire_only = 1'b0;
   logic load = 1'b0;
   logic [31:0] value = 32'h0;
   logic [31:0] q;
   logic err;
   int fails = 0;
   int tests_run = 0;

   // Clock at 50 MHz.
   always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

   hc_irq_frame_regs #(.FRAME_LEN(FL)) hc_irq_frame_regs_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
      .async_ptr_load(async_ptr_load), .async_ptr_value(async_ptr_value),
      .periodic_list_base(periodic_list_base), .async_list_pointer(async_list_pointer),
      .frame_index(frame_index), .configured_bit(configured_bit), .irq(irq));

   engine_model engine_model_inst (.pclk(pclk), .presetn(presetn), .fire(fire),
      .retire_only(retire_only), .load(load), .value(value), .events(events),
      .async_ptr_load(async_ptr_load), .async_ptr_value(async_ptr_value));

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fails++;
         wrap_up();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(q, exp);
   endtask

   // Requests one event pulse from the engine model.
   task automatic pulse(input logic [5:0] f, input logic ro);
      @(posedge pclk);
      fire <= f;
      retire_only <= ro;
      @(posedge pclk);
      fire <= 6'h00;
      retire_only <= 1'b0;
   endtask

   // Bounded wait for the interrupt; a timeout counts a failure and ends the run.
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (irq !== 1'b1 && n < lim);
      // A missing interrupt would stall the scenario, so it ends the run here.
      if (irq !== 1'b1) begin
         fails++;
         wrap_up();
      end
   endtask

   task automatic t_fields();
      rd_chk(OFS_HOST_IRQ_ENABLE, 32'h0);
      rd_chk(OFS_FRAME_INDEX, 32'h0);
      rd_chk(OFS_HC_CONTROL, {16'h0000, THRESHOLD_RESET, 8'h00});
      check(irq, 32'h0);
      wr(OFS_HOST_IRQ_ENABLE, 32'hFFFFFFFF);
      rd_chk(OFS_HOST_IRQ_ENABLE, 32'h0000003F);
      wr(OFS_HOST_IRQ_ENABLE, 32'h0);
      wr(OFS_PERIODIC_BASE, 32'hFFFFFFFF);
      rd_chk(OFS_PERIODIC_BASE, 32'hFFFFF000);
      check(periodic_list_base, 32'hFFFFF000);
      wr(OFS_ASYNC_POINTER, 32'hFFFFFFFF);
      rd_chk(OFS_ASYNC_POINTER, 32'hFFFFFFE0);
      @(posedge pclk);
      load <= 1'b1;
      value <= 32'h1234567F;
      @(posedge pclk);
      load <= 1'b0;
      rd_chk(OFS_ASYNC_POINTER, 32'h12345660);
      check(async_list_pointer, 32'h12345660);
      wr(OFS_CONFIGURED_FLAG, 32'hFFFFFFFF);
      rd_chk(OFS_CONFIGURED_FLAG, 32'h1);
      check(configured_bit, 32'h1);
      rd_chk(8'h40, 32'h0);
      check(err, 32'h1);
      // A retired descriptor without the completion request sets nothing.
      pulse(6'h00, 1'b1);
      rd_chk(OFS_HOST_STATUS, 32'h0);
   endtask

   // Masked, then enabled, then cleared; threshold is one frame.
   task automatic t_src(input int s, input logic imm);
      logic [31:0] b;
      b = 32'h1 << s;
      wr(OFS_HC_CONTROL, 32'h100);
      wr(OFS_HC_CONTROL, 32'h101);
      pulse(b[5:0], 1'b0);
      repeat (3) @(negedge pclk);
      check(irq, 32'h0);
      rd_chk(OFS_HOST_STATUS, b);
      wr(OFS_HOST_IRQ_ENABLE, b);
      wait_irq(2 * FL);
      check(irq, 32'h1);
      wr(OFS_HOST_STATUS, b);
      repeat (2) @(negedge pclk);
      check(irq, 32'h0);
      wr(OFS_HC_CONTROL, 32'h100);
      wr(OFS_HC_CONTROL, 32'h101);
      pulse(b[5:0], 1'b0);
      repeat (2) @(negedge pclk);
      check(irq, {31'h0, imm});
      wait_irq(FL + 5);
      check(irq, 32'h1);
      wr(OFS_HOST_STATUS, b);
      wr(OFS_HOST_IRQ_ENABLE, 32'h0);
   endtask

   task automatic t_frame();
      wr(OFS_HC_CONTROL, 32'h100);
      wr(OFS_HOST_IRQ_ENABLE, 32'h8);
      wr(OFS_FRAME_INDEX, 32'h3FFF);
      rd_chk(OFS_FRAME_INDEX, 32'h3FFF);
      wr(OFS_HC_CONTROL, 32'h101);
      wait_irq(FL + 5);
      check(irq, 32'h1);
      check(frame_index, 32'h0);
      repeat (FL) @(negedge pclk);
      check(frame_index, 32'h1);
      rd_chk(OFS_HOST_STATUS, 32'h8);
      rd_chk(OFS_FRAME_INDEX, 32'h1);
   endtask

   // Threshold of two frames: a deferred source must let the first tick pass.
   task automatic t_thr();
      wr(OFS_HOST_IRQ_ENABLE, 32'h2);
      wr(OFS_HC_CONTROL, 32'h200);
      wr(OFS_HC_CONTROL, 32'h201);
      pulse(6'h02, 1'b0);
      repeat (FL + 5) @(negedge pclk);
      check(irq, 32'h0);
      wait_irq(FL + 5);
      check(irq, 32'h1);
      wr(OFS_HOST_STATUS, 32'h2);
      wr(OFS_HOST_IRQ_ENABLE, 32'h0);
   endtask

   // Reset in mid-run drops a pending interrupt and returns status, enable and frame index to their reset values.
   task automatic t_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check(irq, 32'h0);
      rd_chk(OFS_HOST_STATUS, 32'h0);
      rd_chk(OFS_HOST_IRQ_ENABLE, 32'h0);
      rd_chk(OFS_FRAME_INDEX, {18'h0, FRAME_INDEX_RESET});
   endtask

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_fields();
      t_src(SRC_COMPLETE, 1'b0);
      t_src(SRC_XFER_ERROR, 1'b0);
      t_src(SRC_PORT_CHANGE, 1'b1);
      t_src(SRC_SYS_ERROR, 1'b1);
      t_src(SRC_ASYNC_ADV, 1'b0);
      t_thr();
      t_frame();
      t_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
